// File: verilog/dsc_pkg.sv
// package of phase lengths and states for the dual-slope count sequencer
// assumes one clock mclk, synchronous reset srst, comparator from the analog side
// Function
// - comparator is sampled once per clock, at the settled half-period point
// - comparator glitches near clock edges are never taken as zero crossings
// - counter held off one clock when reference integration starts
// - counter held off one clock when auto-zero starts, overload reads zero
// - signal integration counts with no inserted hold-off clock
// - conversion rate scales linearly with converter clock, 2.5 per second at 100 kHz
// - in continuous mode a new cycle starts every 40,002 clock periods, or 80,004 if the reference phase is still running at period 40,002
// - every cycle opens with an auto-zero phase of 10,001 counts
// - reference integration beyond 20,000 periods raises the range-exceeded output
package dsc_pkg;
    localparam int unsigned cycle_len = 40002;
    localparam int unsigned az_len = 10001;
    localparam int unsigned si_len = 10000;
    localparam int unsigned ri_max = 20000;
    localparam int cnt_w = 16;
    localparam logic [cnt_w-1:0] cnt_reset = 16'h0000;
    typedef enum logic [3:0] {
        dsc_az = 4'h1,
        dsc_si = 4'h2,
        dsc_ri = 4'h4,
        dsc_hold = 4'h8
    } dsc_phase_type;
endpackage

// File: verilog/dsc_if.sv
// carrier between sequencer and zero-crossing sampler
// assumes both ends run on mclk
interface dsc_zc_if;
    logic sample_en;
    logic zero_cross;
    modport sampler (input sample_en, output zero_cross);
    modport seq (output sample_en, input zero_cross);
endinterface

// File: verilog/dsc_zc_sampler.sv
// zero-crossing sampler: synchronises comparator and samples once per period
// assumes sample_en pulses once per conversion clock at its settled point
module dsc_zc_sampler (
    input wire logic mclk,
    input wire logic srst,
    input wire logic comp_in,
    dsc_zc_if.sampler zc
);
    logic sync_a;
    logic sync_b;
    // two flops before anything reads the comparator
    always_ff @(posedge mclk) begin
        sync_a <= comp_in;
        sync_b <= sync_a;
    end
    // only the settled sample counts; edge glitches between samples ignored
    always_ff @(posedge mclk) begin
        if (srst) begin
            zc.zero_cross <= 1'b0;
        end else if (zc.sample_en) begin
            zc.zero_cross <= sync_b;
        end
    end
endmodule // dsc_zc_sampler

// File: verilog/dsc_count_sequencer.sv
// top of the dual-slope count sequencer: phases, result counter, range flag
// assumes conv_tick is a one-cycle enable per converter clock from a divider
module dsc_count_sequencer
    import dsc_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic conv_tick,
    input wire logic comp_in,
    input wire logic run_cont,
    output dsc_pkg::dsc_phase_type phase,
    output logic [dsc_pkg::cnt_w-1:0] result,
    output logic result_valid,
    output logic range_exceeded,
    output logic busy
);
    import dsc_pkg::*;
    dsc_zc_if zc ();
    logic [cnt_w-1:0] phase_cnt;
    logic [cnt_w-1:0] ri_cnt;
    logic [cnt_w-1:0] next_ri_cnt;
    logic [cnt_w-1:0] cyc_cnt;
    logic inhibit;
    logic half_tick;

    dsc_zc_sampler u_zc (
        .mclk(mclk),
        .srst(srst),
        .comp_in(comp_in),
        .zc(zc)
    );

    // sample one mclk after the tick so edge transients have settled
    always_ff @(posedge mclk) begin
        if (srst) begin
            half_tick <= 1'b0;
        end else begin
            half_tick <= conv_tick;
        end
    end
    assign zc.sample_en = half_tick;

    function automatic logic [cnt_w-1:0] cnt_at(input int unsigned n);
        cnt_at = cnt_w'(n - 1);
    endfunction

    // whole-cycle counter: rate is a fixed number of converter clocks
    always_ff @(posedge mclk) begin
        if (srst) begin
            cyc_cnt <= cnt_reset;
        end else if (conv_tick) begin
            if (cyc_cnt == cnt_at(cycle_len)) begin
                cyc_cnt <= cnt_reset;
            end else begin
                cyc_cnt <= cyc_cnt + 16'h0001;
            end
        end
    end

    // phase sequencing; a hold-off clock opens auto-zero and reference phases
    always_ff @(posedge mclk) begin
        if (srst) begin
            phase <= dsc_az;
            phase_cnt <= cnt_reset;
            inhibit <= 1'b1;
        end else if (conv_tick) begin
            inhibit <= 1'b0;
            case (phase)
                dsc_az: begin
                    if (!inhibit) begin
                        if (phase_cnt == cnt_at(az_len - 1)) begin
                            phase <= dsc_si;
                            phase_cnt <= cnt_reset;
                        end else begin
                            phase_cnt <= phase_cnt + 16'h0001;
                        end
                    end
                end
                dsc_si: begin
                    if (phase_cnt == cnt_at(si_len)) begin
                        phase <= dsc_ri;
                        phase_cnt <= cnt_reset;
                        inhibit <= 1'b1;
                    end else begin
                        phase_cnt <= phase_cnt + 16'h0001;
                    end
                end
                dsc_ri: begin
                    phase_cnt <= phase_cnt + 16'h0001;
                end
                dsc_hold: begin
                    // wait out the fixed cycle, then restart if running
                    if (cyc_cnt == cnt_at(cycle_len) && run_cont) begin
                        phase <= dsc_az;
                        phase_cnt <= cnt_reset;
                        inhibit <= 1'b1;
                    end
                end
                default: begin
                    phase <= dsc_az;
                    phase_cnt <= cnt_reset;
                end
            endcase
            if (phase == dsc_ri && (zc.zero_cross || ri_cnt >= cnt_w'(ri_max))) begin
                phase <= dsc_hold;
            end
        end
    end

    // reference count, frozen on the hold-off clock
    always_comb begin
        next_ri_cnt = ri_cnt;
        if (phase == dsc_si) begin
            next_ri_cnt = cnt_reset;
        end else if (phase == dsc_ri && !inhibit) begin
            next_ri_cnt = ri_cnt + 16'h0001;
        end
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            ri_cnt <= cnt_reset;
        end else if (conv_tick) begin
            ri_cnt <= next_ri_cnt;
        end
    end

    // latch the result when the reference phase ends; overload reads zero
    always_ff @(posedge mclk) begin
        if (srst) begin
            result <= cnt_reset;
            result_valid <= 1'b0;
            range_exceeded <= 1'b0;
        end else begin
            result_valid <= 1'b0;
            if (conv_tick && phase == dsc_ri) begin
                if (ri_cnt >= cnt_w'(ri_max)) begin
                    result <= cnt_reset;
                    range_exceeded <= 1'b1;
                    result_valid <= 1'b1;
                end else if (zc.zero_cross) begin
                    result <= ri_cnt;
                    result_valid <= 1'b1;
                end
            end else if (conv_tick && phase == dsc_si) begin
                range_exceeded <= 1'b0;
            end
        end
    end

    assign busy = (phase == dsc_si) || (phase == dsc_ri);
endmodule // dsc_count_sequencer

// File: bench/dsc_analog_model.sv
// integrator and comparator seen from the sequencer
// assumes phase and conv_tick from the sequencer, one mclk domain
module dsc_analog_model
    import dsc_pkg::*;
#(
    parameter int ri_ticks = 100
)
(
    input wire logic mclk,
    input wire logic conv_tick,
    input wire dsc_pkg::dsc_phase_type phase,
    output logic comp_in
);
    int cnt = 0;
    // ramp falls one step per reference period; the tick that enters ri already
    // opens the first period, so the count starts at one
    // comparator rises once the ramp crosses zero; no comparator delay is
    // modelled, so the fixed offset downstream may subtract is zero
    always_ff @(posedge mclk) begin
        if (phase == dsc_si)
            cnt <= 1;
        else if (phase == dsc_ri && conv_tick)
            cnt <= cnt + 1;
        comp_in <= (phase inside {dsc_ri, dsc_hold} && cnt >= ri_ticks);
    end
endmodule // dsc_analog_model

// File: bench/dsc_count_monitor.sv
// checker on the sequencer's top ports
// assumes mclk clock, srst synchronous active high
module dsc_count_monitor
    import dsc_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire dsc_pkg::dsc_phase_type phase,
    input wire logic [dsc_pkg::cnt_w-1:0] result,
    input wire logic result_valid,
    input wire logic range_exceeded,
    input wire logic busy
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);
    a_busy_phase: assert property (busy == (phase inside {dsc_si, dsc_ri}))
        else $error("busy does not follow phase");
    a_valid_pulse: assert property (result_valid |=> !result_valid)
        else $error("valid longer than one cycle");
    a_valid_hold: assert property (result_valid |-> phase == dsc_hold)
        else $error("valid outside hold");
    a_result_load: assert property ($changed(result) |-> result_valid)
        else $error("result moved without valid");
    a_overload_zero: assert property (result_valid && range_exceeded |-> result == cnt_reset)
        else $error("overload result not zero");
    a_phase_onehot: assert property ($onehot(phase))
        else $error("phase not one-hot");
    a_ri_after_si: assert property ($rose(phase == dsc_ri) |-> $past(phase) == dsc_si)
        else $error("reference phase not after signal phase");
    a_si_after_az: assert property ($rose(phase == dsc_si) |-> $past(phase) == dsc_az)
        else $error("signal phase not after auto-zero");
endmodule // dsc_count_monitor
bind dsc_count_sequencer dsc_count_monitor u_mon (.mclk(mclk), .srst(srst), .phase(phase),
    .result(result), .result_valid(result_valid), .range_exceeded(range_exceeded), .busy(busy));

// File: bench/tb.sv
// bench for the count sequencer: one full conversion and restart
// assumes ticks every second mclk, analog model on comp_in
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import dsc_pkg::*;
    localparam int ri_n = 100;
    logic mclk = 0;
    logic srst = 1;
    logic conv_tick = 0;
    logic run_cont = 1;
    logic comp_in, result_valid, range_exceeded, busy;
    logic [cnt_w-1:0] result;
    dsc_phase_type phase;
    int n_errors = 0;
    int n_checks = 0;
    int ticks = 0;
    always #20 mclk = ~mclk;
    // fastest legal tick spacing keeps a whole cycle inside the run budget
    always @(posedge mclk) begin
        if (!srst)
            conv_tick <= ~conv_tick;
        if (conv_tick)
            ticks <= ticks + 1;
    end
    dsc_analog_model #(.ri_ticks(ri_n)) u_ana (.mclk(mclk), .conv_tick(conv_tick),
        .phase(phase), .comp_in(comp_in));
    dsc_count_sequencer dut (.mclk(mclk), .srst(srst), .conv_tick(conv_tick), .comp_in(comp_in),
        .run_cont(run_cont), .phase(phase), .result(result), .result_valid(result_valid),
        .range_exceeded(range_exceeded), .busy(busy));
    task automatic print_verdict();
        if (n_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // bounded wait, a run-out counts as a mismatch
    task automatic wait_for(logic [3:0] p, logic valid);
        for (int i = 0; i < 90000 && (valid ? result_valid !== 1'b1 : phase !== p); i++)
            @(negedge mclk);
        check(valid ? "valid wait" : "phase wait", 1, valid ? result_valid : phase == p);
        if (n_errors != 0)
            print_verdict();
    endtask
    task automatic t_reset();
        check("reset phase", dsc_az, phase);
        check("reset result", 0, result);
        check("reset busy", 0, busy);
    endtask
    task automatic t_phases();
        wait_for(dsc_si, 0);
        check("auto-zero ticks", az_len, ticks);
        check("busy in si", 1, busy);
        wait_for(dsc_ri, 0);
        check("signal ticks", az_len + si_len, ticks);
    endtask
    task automatic t_convert();
        wait_for(dsc_hold, 1);
        check("result", ri_n, result);
        check("range flag", 0, range_exceeded);
        @(negedge mclk);
        check("busy after", 0, busy);
    endtask
    task automatic t_restart();
        wait_for(dsc_az, 0);
        check("cycle ticks", cycle_len, ticks);
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        @(negedge mclk);
        t_reset();
        t_phases();
        t_convert();
        t_restart();
        print_verdict();
    end
endmodule // tb
